// ===== rtl/lrc_ladder_ref.sv
`timescale 1ns/1ps
module lrc_ladder_ref (
  // Clock and reset
  input wire logic I_CLOCK,
  input wire logic I_SYS_RST,
  // AXI4-Lite write address
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [lrc_pkg::ADDR_W-1:0] I_AWADDR,
  input wire logic [2:0] I_AWPROT,
  // AXI4-Lite write data
  input wire logic I_WVALID,
  output logic O_WREADY,
  input wire logic [lrc_pkg::DATA_W-1:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  // AXI4-Lite write response
  output logic O_BVALID,
  input wire logic I_BREADY,
  output logic [1:0] O_BRESP,
  // AXI4-Lite read address
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  input wire logic [lrc_pkg::ADDR_W-1:0] I_ARADDR,
  input wire logic [2:0] I_ARPROT,
  // AXI4-Lite read data
  output logic O_RVALID,
  input wire logic I_RREADY,
  output logic [lrc_pkg::DATA_W-1:0] O_RDATA,
  output logic [1:0] O_RRESP,
  // Ladder controls
  output logic O_LADDER_POWER_EN,
  output logic O_RANGE_LOW,
  output logic [lrc_pkg::TAP_W-1:0] O_TAP_SEL,
  output logic [lrc_pkg::LEVEL_W-1:0] O_LEVEL_CODE,
  // Routing of the selected level
  output logic O_PIN_ROUTE_EN,
  output logic O_CMP_POS_REF_SEL
);

  // ****************************************************************
  // Address decode
  // ****************************************************************

  // Maps a byte address to a register
  function automatic lrc_pkg::lrc_sel_t decode_sel(
    input logic [lrc_pkg::ADDR_W-1:0] addr
  );
    lrc_pkg::lrc_sel_t sel;
    sel = lrc_pkg::SEL_NONE;
    if (addr == lrc_pkg::REF_CTRL_ADDR) begin
      sel = lrc_pkg::SEL_REF_CTRL;
    end else if (addr == lrc_pkg::CMP_CTRL_ADDR) begin
      sel = lrc_pkg::SEL_CMP_CTRL;
    end else if (addr == lrc_pkg::PORT_DIR_ADDR) begin
      sel = lrc_pkg::SEL_PORT_DIR;
    end else if (addr == lrc_pkg::REF_STAT_ADDR) begin
      sel = lrc_pkg::SEL_REF_STAT;
    end
    return sel;
  endfunction

  // ****************************************************************
  // Write channel
  // ****************************************************************

  logic aw_held_q;
  logic w_held_q;
  logic [lrc_pkg::ADDR_W-1:0] aw_addr_q;
  logic [7:0] w_byte_q;
  logic w_lane_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic do_write;
  lrc_pkg::lrc_sel_t wr_sel;

  // Each channel is taken once, then held until the response
  assign O_AWREADY = !aw_held_q && !bvalid_q;
  assign O_WREADY = !w_held_q && !bvalid_q;
  assign do_write = aw_held_q && w_held_q && !bvalid_q;
  assign wr_sel = decode_sel(aw_addr_q);

  // Capture of write address
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (I_AWVALID && O_AWREADY) begin
      aw_held_q <= 1'b1;
      aw_addr_q <= I_AWADDR;
    end else if (do_write) begin
      aw_held_q <= 1'b0;
    end
  end

  // Capture of write data, low byte lane only
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      w_held_q <= 1'b0;
      w_byte_q <= 8'h00;
      w_lane_q <= 1'b0;
    end else if (I_WVALID && O_WREADY) begin
      w_held_q <= 1'b1;
      w_byte_q <= I_WDATA[7:0];
      w_lane_q <= I_WSTRB[0];
    end else if (do_write) begin
      w_held_q <= 1'b0;
    end
  end

  // Write response
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      bvalid_q <= 1'b0;
      bresp_q <= lrc_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q <= (wr_sel == lrc_pkg::SEL_NONE) ?
                 lrc_pkg::RESP_SLVERR : lrc_pkg::RESP_OKAY;
    end else if (I_BREADY) begin
      bvalid_q <= 1'b0;
    end
  end

  assign O_BVALID = bvalid_q;
  assign O_BRESP = bresp_q;

  // ****************************************************************
  // Registers
  // ****************************************************************

  logic [7:0] ref_ctrl_q;
  logic [2:0] cmp_mode_q;
  logic [4:0] port_dir_q;
  logic wr_lane;

  assign wr_lane = do_write && w_lane_q;

  // Reference control; no wake input, so sleep leaves it intact
  // cleared by every reset
  // only reset or write change it
  // updated on the write's completing edge
  // bit four masked off on write
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      ref_ctrl_q <= lrc_pkg::REF_CTRL_RST;
    end else if (wr_lane && wr_sel == lrc_pkg::SEL_REF_CTRL) begin
      ref_ctrl_q <= w_byte_q & lrc_pkg::REF_CTRL_MASK;
    end
  end

  // Comparator mode field
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      cmp_mode_q <= lrc_pkg::CMP_MODE_RST;
    end else if (wr_lane && wr_sel == lrc_pkg::SEL_CMP_CTRL) begin
      cmp_mode_q <= w_byte_q[2:0];
    end
  end

  // Port direction bits, set means input
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      port_dir_q <= lrc_pkg::PORT_DIR_RST;
    end else if (wr_lane && wr_sel == lrc_pkg::SEL_PORT_DIR) begin
      port_dir_q <= w_byte_q[4:0];
    end
  end

  // ****************************************************************
  // Ladder outputs
  // ****************************************************************

  logic [lrc_pkg::TAP_W-1:0] tap;
  logic [lrc_pkg::LEVEL_W-1:0] low_code;
  logic [lrc_pkg::LEVEL_W-1:0] high_code;

  assign O_LADDER_POWER_EN = ref_ctrl_q[lrc_pkg::POWER_BIT];
  assign O_RANGE_LOW = ref_ctrl_q[lrc_pkg::RANGE_BIT];
  assign tap = ref_ctrl_q[lrc_pkg::TAP_LSB +: lrc_pkg::TAP_W];
  assign O_TAP_SEL = tap;

  assign low_code = {1'b0, tap, 2'b00};
  assign high_code = lrc_pkg::HIGH_RANGE_BASE + {2'b00, tap, 1'b0}
                     + {3'b000, tap};
  assign O_LEVEL_CODE = O_RANGE_LOW ? low_code : high_code;

  // pin needs input direction and enable
  // bit six routes to the pin
  assign O_PIN_ROUTE_EN = ref_ctrl_q[lrc_pkg::PIN_BIT]
                          && port_dir_q[lrc_pkg::PIN_DIR_BIT];
  assign O_CMP_POS_REF_SEL = (cmp_mode_q == lrc_pkg::CMP_MODE_INT_REF);

  // ****************************************************************
  // Read channel
  // ****************************************************************

  logic rvalid_q;
  logic [lrc_pkg::DATA_W-1:0] rdata_q;
  logic [1:0] rresp_q;
  logic [7:0] rd_byte;
  lrc_pkg::lrc_sel_t rd_sel;

  assign O_ARREADY = !rvalid_q;
  assign rd_sel = decode_sel(I_ARADDR);

  // Read mux; status shows effective routing
  always_comb begin
    rd_byte = 8'h00;
    if (rd_sel == lrc_pkg::SEL_REF_CTRL) begin
      rd_byte = ref_ctrl_q;
    end else if (rd_sel == lrc_pkg::SEL_CMP_CTRL) begin
      rd_byte = {5'h00, cmp_mode_q};
    end else if (rd_sel == lrc_pkg::SEL_PORT_DIR) begin
      rd_byte = {3'h0, port_dir_q};
    end else if (rd_sel == lrc_pkg::SEL_REF_STAT) begin
      rd_byte = {5'h00, O_CMP_POS_REF_SEL, O_PIN_ROUTE_EN,
                 O_LADDER_POWER_EN};
    end
  end

  // Read data and response
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= lrc_pkg::RESP_OKAY;
    end else if (I_ARVALID && O_ARREADY) begin
      rvalid_q <= 1'b1;
      rdata_q <= {24'h000000, rd_byte};
      rresp_q <= (rd_sel == lrc_pkg::SEL_NONE) ?
                 lrc_pkg::RESP_SLVERR : lrc_pkg::RESP_OKAY;
    end else if (I_RREADY) begin
      rvalid_q <= 1'b0;
    end
  end

  assign O_RVALID = rvalid_q;
  assign O_RDATA = rdata_q;
  assign O_RRESP = rresp_q;

  // ****************************************************************
  // Assertions
  // ****************************************************************

  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (I_SYS_RST);

  // Write to control register with the low lane
  sequence ctrl_write_s;
    do_write && w_lane_q && wr_sel == lrc_pkg::SEL_REF_CTRL;
  endsequence

  // Response raised, master not yet ready
  sequence resp_wait_s;
    O_BVALID && !I_BREADY;
  endsequence

  // Response raised and taken by the master
  sequence resp_taken_s;
    O_BVALID && I_BREADY;
  endsequence

  ctrl_write_upd_a: assert property (
    ctrl_write_s |=> O_BVALID && O_TAP_SEL == $past(w_byte_q[3:0])
      && O_LADDER_POWER_EN == $past(w_byte_q[7]))
    else $error("control write did not update ladder outputs");

  reserved_bit_zero_a: assert property (
    ref_ctrl_q[4] == 1'b0)
    else $error("unimplemented control bit is set");

  reset_clear_a: assert property (
    @(posedge I_CLOCK) disable iff (1'b0)
    I_SYS_RST |=> ref_ctrl_q == lrc_pkg::REF_CTRL_RST
      && !O_LADDER_POWER_EN && !O_PIN_ROUTE_EN)
    else $error("control register not cleared by reset");

  ctrl_hold_a: assert property (
    !$past(do_write) |-> $stable(ref_ctrl_q))
    else $error("control register changed without a write");

  pin_route_gate_a: assert property (
    O_PIN_ROUTE_EN == (ref_ctrl_q[6] && port_dir_q[2]))
    else $error("pin routing ignores direction or enable");

  cmp_ref_mode_a: assert property (
    O_CMP_POS_REF_SEL == (cmp_mode_q == 3'h2))
    else $error("comparator reference select wrong for mode");

  low_level_a: assert property (
    O_RANGE_LOW |-> O_LEVEL_CODE == 7'(4 * O_TAP_SEL))
    else $error("low range level code wrong");

  high_level_a: assert property (
    !O_RANGE_LOW |-> O_LEVEL_CODE == 7'(24 + 3 * O_TAP_SEL))
    else $error("high range level code wrong");

  cmp_indep_a: assert property (
    $changed(cmp_mode_q) |->
      $stable(O_TAP_SEL) && $stable(O_LADDER_POWER_EN))
    else $error("ladder follows comparator mode");

  bresp_order_a: assert property (
    do_write |=> O_BVALID)
    else $error("write response not raised after write");

  bresp_hold_a: assert property (
    resp_wait_s |=> O_BVALID && $stable(O_BRESP))
    else $error("write response not held until taken");

  bresp_drop_a: assert property (
    resp_taken_s |=> !O_BVALID)
    else $error("write response not dropped after taken");

  read_back_a: assert property (
    I_ARVALID && O_ARREADY && rd_sel == lrc_pkg::SEL_REF_CTRL
      |=> O_RVALID && O_RDATA[7:0] == $past(ref_ctrl_q)
      && O_RRESP == lrc_pkg::RESP_OKAY)
    else $error("control register read back wrong");

  power_bit_a: assert property (
    O_LADDER_POWER_EN == ref_ctrl_q[7]
      && O_RANGE_LOW == ref_ctrl_q[5])
    else $error("power or range output mismatch");

endmodule

// ===== rtl/lrc_pkg.sv
// ****************************************************************
// Register map and field layout
// ****************************************************************
package lrc_pkg;

  // Bus widths
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // Register indices; byte address is four times the index
  localparam logic [7:0] REF_CTRL_IDX = 8'h9F;
  localparam logic [7:0] CMP_CTRL_IDX = 8'h1F;
  localparam logic [7:0] PORT_DIR_IDX = 8'h85;
  localparam logic [7:0] REF_STAT_IDX = 8'hA0;

  // Byte addresses derived from the indices
  localparam logic [ADDR_W-1:0] REF_CTRL_ADDR = {2'h0, REF_CTRL_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] CMP_CTRL_ADDR = {2'h0, CMP_CTRL_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] PORT_DIR_ADDR = {2'h0, PORT_DIR_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] REF_STAT_ADDR = {2'h0, REF_STAT_IDX, 2'h0};

  // Reference control field positions
  localparam int POWER_BIT = 7;
  localparam int PIN_BIT = 6;
  localparam int RANGE_BIT = 5;
  localparam int TAP_LSB = 0;
  localparam int TAP_W = 4;

  // Writable bits of the reference control register
  localparam logic [7:0] REF_CTRL_MASK = 8'hEF;

  // Reset values
  localparam logic [7:0] REF_CTRL_RST = 8'h00;
  localparam logic [2:0] CMP_MODE_RST = 3'h0;
  localparam logic [4:0] PORT_DIR_RST = 5'h1F;

  // Port direction bit of the analog output pin
  localparam int PIN_DIR_BIT = 2;

  // Comparator mode that selects the internal reference
  localparam logic [2:0] CMP_MODE_INT_REF = 3'h2;

  // Level code in 96ths of supply
  localparam int LEVEL_W = 7;
  localparam logic [LEVEL_W-1:0] HIGH_RANGE_BASE = 7'h18;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Register selected by an address
  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_REF_CTRL,
    SEL_CMP_CTRL,
    SEL_PORT_DIR,
    SEL_REF_STAT
  } lrc_sel_t;

endpackage

// ===== testbench/lrc_far_side.sv
`timescale 1ns/1ps
// Comparator inputs and analog pin beside the ladder
module lrc_far_side #(
  parameter int SETTLE = 4
) (
  // Clock
  input wire logic i_clock,
  // Ladder state
  input wire logic i_power_en,
  input wire logic i_route_en,
  input wire logic i_cmp_sel,
  input wire logic [6:0] i_level,
  // Observed levels
  output logic [6:0] o_pin_level,
  output logic [6:0] o_cmp_level,
  output logic o_settled
);
  logic [6:0] lvl_q;
  logic [6:0] pin_q;
  int age_q = 0;
  wire logic [6:0] lvl = i_power_en ? i_level : 7'h00;
  always_ff @(posedge i_clock) begin
    lvl_q <= lvl;
    age_q <= (lvl != lvl_q) ? 0 : (age_q < SETTLE ? age_q + 1 : age_q);
  end
  assign o_settled = (age_q == SETTLE);
  always_ff @(posedge i_clock) begin
    if (i_route_en) pin_q <= lvl;
  end
  assign o_pin_level = i_route_en ? lvl : ~pin_q;
  assign o_cmp_level = i_cmp_sel ? lvl : ~lvl;
endmodule

// ===== testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  localparam logic [11:0] CA = lrc_pkg::REF_CTRL_ADDR;
  localparam logic [11:0] MA = lrc_pkg::CMP_CTRL_ADDR;
  localparam logic [11:0] PA = lrc_pkg::PORT_DIR_ADDR;
  localparam logic [11:0] SA = lrc_pkg::REF_STAT_ADDR;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic awv = 1'b0;
  logic wv = 1'b0;
  logic br = 1'b0;
  logic arv = 1'b0;
  logic rr = 1'b0;
  logic [11:0] awa = 12'h000;
  logic [11:0] ara = 12'h000;
  logic [31:0] wd = 32'h00000000;
  logic [31:0] d;
  logic [31:0] rdata;
  logic [1:0] r;
  logic [1:0] bresp;
  logic [1:0] rresp;
  logic awr, wrdy, bv, arr, rv, pwr, rlow, route, csel, settled;
  logic [3:0] tap;
  logic [3:0] tap_b;
  logic [6:0] lvl, pin_lvl, cmp_lvl;
  int err_count = 0;
  int n_compared = 0;

  lrc_ladder_ref u_lrc_ladder_ref (
    .I_CLOCK(clk), .I_SYS_RST(rst),
    .I_AWVALID(awv), .O_AWREADY(awr), .I_AWADDR(awa), .I_AWPROT(3'h0),
    .I_WVALID(wv), .O_WREADY(wrdy), .I_WDATA(wd), .I_WSTRB(4'hF),
    .O_BVALID(bv), .I_BREADY(br), .O_BRESP(bresp),
    .I_ARVALID(arv), .O_ARREADY(arr), .I_ARADDR(ara), .I_ARPROT(3'h0),
    .O_RVALID(rv), .I_RREADY(rr), .O_RDATA(rdata), .O_RRESP(rresp),
    .O_LADDER_POWER_EN(pwr), .O_RANGE_LOW(rlow), .O_TAP_SEL(tap),
    .O_LEVEL_CODE(lvl), .O_PIN_ROUTE_EN(route), .O_CMP_POS_REF_SEL(csel)
  );

  lrc_far_side u_lrc_far_side (
    .i_clock(clk), .i_power_en(pwr), .i_route_en(route),
    .i_cmp_sel(csel), .i_level(lvl), .o_pin_level(pin_lvl),
    .o_cmp_level(cmp_lvl), .o_settled(settled)
  );

  // Free-running clock
  initial begin
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic hang;
    err_count++;
    $display("unexpected at %0t: wait ran out", $time);
    give_verdict();
  endtask

  // Write; bus response left in r
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    logic ta, tw, tb;
    tb = 1'b0;
    @(posedge clk);
    awv <= 1'b1;
    wv <= 1'b1;
    awa <= a;
    wd <= v;
    br <= 1'b1;
    for (int n = 0; n < 40 && !tb; n++) begin
      @(negedge clk);
      ta = awv && awr;
      tw = wv && wrdy;
      tb = bv;
      r = bresp;
      tap_b = tap;
      @(posedge clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
      if (tb) br <= 1'b0;
    end
    if (!tb) hang();
    @(negedge clk);
  endtask

  // Read; word in d, response in r
  task automatic rd(input logic [11:0] a);
    logic ta, tr;
    tr = 1'b0;
    @(posedge clk);
    arv <= 1'b1;
    ara <= a;
    rr <= 1'b1;
    for (int n = 0; n < 40 && !tr; n++) begin
      @(negedge clk);
      ta = arv && arr;
      tr = rv;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ta) arv <= 1'b0;
      if (tr) rr <= 1'b0;
    end
    if (!tr) hang();
    @(negedge clk);
  endtask

  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(CA);
    chk(d, 32'h00000000);
    wr(CA, 32'h000000FF);
    chk(r, lrc_pkg::RESP_OKAY);
    rd(CA);
    chk(d, 32'h000000EF);
    chk(pwr, 1'b1);
    chk(route, 1'b1);
    chk(pin_lvl, 7'h3C);
    wr(PA, 32'h0000001B);
    chk(route, 1'b0);
    wr(PA, 32'h00000004);
    wr(CA, 32'h000000AF);
    chk(route, 1'b0);
    // Every tap in both ranges
    for (int t = 0; t < 16; t++) begin
      wr(CA, 32'h000000A0 | 32'(t));
      chk(tap_b, 32'(t));
      chk(rlow, 1'b1);
      chk(lvl, 32'(4 * t));
      wr(CA, 32'h00000080 | 32'(t));
      chk(tap, 32'(t));
      chk(rlow, 1'b0);
      chk(lvl, 32'(24 + 3 * t));
    end
    // Comparator modes leave the ladder alone
    for (int m = 0; m < 8; m++) begin
      wr(MA, 32'(m));
      chk(csel, m == 2);
      chk({pwr, tap, lvl}, {1'b1, 4'hF, 7'h45});
    end
    wr(MA, 32'h00000002);
    wr(CA, 32'h00000085);
    for (int n = 0; n < 50 && !settled; n++) @(negedge clk);
    if (settled !== 1'b1) hang();
    chk(cmp_lvl, 7'h27);
    repeat (50) @(posedge clk);
    rd(CA);
    chk(d, 32'h00000085);
    wr(CA, 32'h00000005);
    chk(pwr, 1'b0);
    wr(12'h004, 32'h000000FF);
    chk(r, lrc_pkg::RESP_SLVERR);
    rd(12'h004);
    chk(d, 32'h00000000);
    chk(r, lrc_pkg::RESP_SLVERR);
    rd(SA);
    chk(d, 32'h00000004);
    chk(r, lrc_pkg::RESP_OKAY);
    wr(CA, 32'h000000E3);
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk({pwr, rlow, tap, csel}, 7'h00);
    rd(CA);
    chk(d, 32'h00000000);
    give_verdict();
  end
endmodule
